// ---- hdl/rcims_defines.svh ----
// Addresses, field positions and reset values of the radio core
// identification, capability and interrupt mask/status registers.
// Assumes a 32-bit APB with byte addresses, one word per register.
`ifndef RCIMS_DEFINES_SVH
`define RCIMS_DEFINES_SVH

// Register byte addresses
`define RCIMS_ADDR_CTRL 32'h4000_0000
`define RCIMS_ADDR_VERSION 32'h4000_0004
`define RCIMS_ADDR_CONFIG 32'h4000_0008
`define RCIMS_ADDR_MASK 32'h4000_000C
`define RCIMS_ADDR_STAT 32'h4000_0010
`define RCIMS_ADDR_RAW 32'h4000_0014
`define RCIMS_ADDR_ACK 32'h4000_0018

// Version word byte fields
`define RCIMS_VER_KIND_HI 31
`define RCIMS_VER_KIND_LO 24
`define RCIMS_VER_MAJOR_HI 23
`define RCIMS_VER_MAJOR_LO 16
`define RCIMS_VER_MINOR_HI 15
`define RCIMS_VER_MINOR_LO 8
`define RCIMS_VER_BUILD_HI 7
`define RCIMS_VER_BUILD_LO 0

// Configuration word fields
`define RCIMS_CFG_AW_HI 29
`define RCIMS_CFG_AW_LO 24
`define RCIMS_CFG_PORT_HI 22
`define RCIMS_CFG_PORT_LO 16
`define RCIMS_CFG_FREQ_HI 13
`define RCIMS_CFG_FREQ_LO 8
`define RCIMS_CFG_UNSCR 6
`define RCIMS_CFG_DUAL 5
`define RCIMS_CFG_LEVEL 4
`define RCIMS_CFG_ARB 3
`define RCIMS_CFG_DIAG 2
`define RCIMS_CFG_AES 1
`define RCIMS_CFG_BUS 0
`define RCIMS_CFG_AW_RST 6'h0F

// Mask register layout and reset value
`define RCIMS_MSK_TICKDEV 15
`define RCIMS_SRC_N 10
`define RCIMS_MSK_RST 10'h11F
`define RCIMS_TICKDEV_RST 1'b1

// Source positions in mask, status, raw and acknowledge words
`define RCIMS_SRC_SOFT 9
`define RCIMS_SRC_ABORT 8
`define RCIMS_SRC_FINE 7
`define RCIMS_SRC_COARSE 6
`define RCIMS_SRC_FAULT 5
`define RCIMS_SRC_CIPHER 4
`define RCIMS_SRC_DONE 3
`define RCIMS_SRC_WAKE 2
`define RCIMS_SRC_RX 1
`define RCIMS_SRC_TICK 0

// Control word: software interrupt request bit
`define RCIMS_CTRL_SOFTREQ 28

`endif

// ---- hdl/rcims_pkg.sv ----
// Types shared by the radio core interrupt mask/status front end.
// Assumes nothing beyond the defines header.
package rcims_pkg;

   // Which register an APB address selects
   typedef enum logic [2:0] {
      RCIMS_SEL_NONE,
      RCIMS_SEL_CTRL,
      RCIMS_SEL_VERSION,
      RCIMS_SEL_CONFIG,
      RCIMS_SEL_MASK,
      RCIMS_SEL_STAT,
      RCIMS_SEL_RAW,
      RCIMS_SEL_ACK
   } rcims_sel_t;

endpackage : rcims_pkg

// ---- hdl/rcims_top.sv ----
// Radio core identification, capability, interrupt mask and status
// registers behind an APB slave, with one level interrupt output.
// Assumes event pulses arrive synchronous to CLK, one cycle each.
//
// Function
// - Read-only version word: kind, major, minor update, build bytes.
// - Config bits 29:24 report address width, reset value fifteen.
// - Config bits 13:8 give operating frequency in megahertz.
// - Config bit 4 reads one: interrupts are levels until acknowledged.
// - Config bits 6 and 5 read zero: no unscrambler, standalone.
// - Config bits 3, 2, 1 read one: arbitration, diag, AES-CCM present.
// - Config bit 0 reads one: processor port is 32 bits wide.
// - Mask bit 15 permits tick interrupt during events; reset on.
// - Mask bits 9..0 each allow or block one source.
// - Reset masks: soft, fine, coarse, fault off; others on.
// - Status bits show sources only after masking.
// - Bit order: soft, abort, fine, coarse, fault, cipher, done, wake, rx, tick.
// - Status bit 0 flags the 625 us base tick.
// - Status bit 3 flags end of an air event.
// - Status bit 4 flags cipher engine completion.
// - Status bit 2 flags end of sleep.
// - Status bits 7 and 6 flag fine and coarse target timers.
// - Raw flag per source records pending regardless of mask.
// - Writing one to an acknowledge bit clears raw and masked flag.
// - Soft request bit raises soft interrupt, then reads back zero.
`timescale 1ns/1ps
`include "rcims_defines.svh"

module rcims_top #(
   parameter logic [7:0] CORE_KIND = 8'h5A, // Value is arbitrary
   parameter logic [7:0] MAJOR_VERSION = 8'h03, // Value is arbitrary
   parameter logic [7:0] MINOR_UPDATE_NUMBER = 8'h04, // Value is arbitrary
   parameter logic [7:0] BUILD_NUMBER = 8'h05, // Value is arbitrary
   parameter logic [6:0] RADIO_PORT_ID = 7'h11, // Value is arbitrary
   parameter logic [5:0] CORE_FREQ_MHZ = 6'h00
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic EVENT_ACTIVE,
   input wire logic [8:0] SRC_EVENT,
   output logic [9:0] IRQ_STATUS,
   output logic IRQ
);

   // Address decode, shared by read and write paths
   function automatic rcims_pkg::rcims_sel_t decode(input logic [31:0] addr);
      rcims_pkg::rcims_sel_t s;
      s = rcims_pkg::RCIMS_SEL_NONE;
      case (addr)
         `RCIMS_ADDR_CTRL: s = rcims_pkg::RCIMS_SEL_CTRL;
         `RCIMS_ADDR_VERSION: s = rcims_pkg::RCIMS_SEL_VERSION;
         `RCIMS_ADDR_CONFIG: s = rcims_pkg::RCIMS_SEL_CONFIG;
         `RCIMS_ADDR_MASK: s = rcims_pkg::RCIMS_SEL_MASK;
         `RCIMS_ADDR_STAT: s = rcims_pkg::RCIMS_SEL_STAT;
         `RCIMS_ADDR_RAW: s = rcims_pkg::RCIMS_SEL_RAW;
         `RCIMS_ADDR_ACK: s = rcims_pkg::RCIMS_SEL_ACK;
         default: s = rcims_pkg::RCIMS_SEL_NONE;
      endcase
      return s;
   endfunction : decode

   // Masked view of the raw flags; used for status word and output
   function automatic logic [9:0] apply_mask(
      input logic [9:0] raw,
      input logic [9:0] msk,
      input logic tick_dev,
      input logic in_event
   );
      logic [9:0] m;
      m = raw & msk;
      // Tick held off while an event runs, unless permitted
      if (in_event && !tick_dev) begin
         m[`RCIMS_SRC_TICK] = 1'b0;
      end
      return m;
   endfunction : apply_mask

   rcims_pkg::rcims_sel_t sel;
   logic access;
   logic wr_fire;
   logic rd_start;
   logic [9:0] mask_r;
   logic tick_dev_r;
   logic [9:0] raw_word;
   logic soft_irq_raw_r;
   logic event_prefetch_abort_raw_r;
   logic fine_target_raw_r;
   logic coarse_target_raw_r;
   logic fault_raw_r;
   logic cipher_raw_r;
   logic event_done_raw_r;
   logic wake_raw_r;
   logic receive_raw_r;
   logic tick_raw_r;
   logic [9:0] raw_nxt;
   logic [9:0] ack_set;
   logic [9:0] src_set;
   logic soft_req;
   logic [9:0] masked;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [9:0] status_r;
   logic irq_r;
   logic [31:0] version_word;
   logic [31:0] config_word;
   logic [31:0] rd_word;

   // Bus phase qualifiers
   assign sel = decode(PADDR);
   assign access = PSEL && PENABLE;
   assign rd_start = access && !pready_r;
   // Write lands only at the edge where PREADY is seen high
   assign wr_fire = access && pready_r && PWRITE;

   // Fixed identification word
   always_comb begin
      version_word = 32'h0000_0000;
      version_word[`RCIMS_VER_KIND_HI:`RCIMS_VER_KIND_LO] = CORE_KIND;
      version_word[`RCIMS_VER_MAJOR_HI:`RCIMS_VER_MAJOR_LO] = MAJOR_VERSION;
      version_word[`RCIMS_VER_MINOR_HI:`RCIMS_VER_MINOR_LO] =
         MINOR_UPDATE_NUMBER;
      version_word[`RCIMS_VER_BUILD_HI:`RCIMS_VER_BUILD_LO] = BUILD_NUMBER;
   end

   // Fixed capability word; unlisted bits stay zero
   always_comb begin
      config_word = 32'h0000_0000;
      config_word[`RCIMS_CFG_AW_HI:`RCIMS_CFG_AW_LO] = `RCIMS_CFG_AW_RST;
      config_word[`RCIMS_CFG_PORT_HI:`RCIMS_CFG_PORT_LO] = RADIO_PORT_ID;
      config_word[`RCIMS_CFG_FREQ_HI:`RCIMS_CFG_FREQ_LO] = CORE_FREQ_MHZ;
      config_word[`RCIMS_CFG_UNSCR] = 1'b0;
      config_word[`RCIMS_CFG_DUAL] = 1'b0;
      config_word[`RCIMS_CFG_LEVEL] = 1'b1;
      config_word[`RCIMS_CFG_ARB] = 1'b1;
      config_word[`RCIMS_CFG_DIAG] = 1'b1;
      config_word[`RCIMS_CFG_AES] = 1'b1;
      config_word[`RCIMS_CFG_BUS] = 1'b1;
   end

   // Soft request and acknowledges exist only as write strobes,
   // so there is nothing to self-clear and they always read zero
   always_comb begin
      soft_req = 1'b0;
      ack_set = 10'h000;
      if (wr_fire && sel == rcims_pkg::RCIMS_SEL_CTRL) begin
         soft_req = PWDATA[`RCIMS_CTRL_SOFTREQ];
      end
      if (wr_fire && sel == rcims_pkg::RCIMS_SEL_ACK) begin
         ack_set = PWDATA[`RCIMS_SRC_N-1:0];
      end
   end

   // Source set vector in the common bit order
   always_comb begin
      src_set = {soft_req, SRC_EVENT};
   end

   // Raw flags: a new event beats an acknowledge in the same cycle
   always_comb begin
      raw_nxt = (raw_word & ~ack_set) | src_set;
   end

   // Software request flag; set by a control write strobe
   // Kept even while masked, so unmasking later shows it
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         soft_irq_raw_r <= 1'b0;
      end else begin
         soft_irq_raw_r <= raw_nxt[`RCIMS_SRC_SOFT];
      end
   end

   // Event or prefetch abort flag
   // A pulse held high re-sets the flag every cycle
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         event_prefetch_abort_raw_r <= 1'b0;
      end else begin
         event_prefetch_abort_raw_r <= raw_nxt[`RCIMS_SRC_ABORT];
      end
   end

   // Fine target timer flag
   // Set beats a same-cycle acknowledge, so no event is lost
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         fine_target_raw_r <= 1'b0;
      end else begin
         fine_target_raw_r <= raw_nxt[`RCIMS_SRC_FINE];
      end
   end

   // Coarse target timer flag
   // Cleared only by its own acknowledge bit
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         coarse_target_raw_r <= 1'b0;
      end else begin
         coarse_target_raw_r <= raw_nxt[`RCIMS_SRC_COARSE];
      end
   end

   // Fault flag
   // Survives mask changes; only an acknowledge clears it
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         fault_raw_r <= 1'b0;
      end else begin
         fault_raw_r <= raw_nxt[`RCIMS_SRC_FAULT];
      end
   end

   // Cipher engine completion flag
   // One flag per source: repeated pulses are not counted
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cipher_raw_r <= 1'b0;
      end else begin
         cipher_raw_r <= raw_nxt[`RCIMS_SRC_CIPHER];
      end
   end

   // End of air event flag
   // Independent of EVENT_ACTIVE, which gates the tick only
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         event_done_raw_r <= 1'b0;
      end else begin
         event_done_raw_r <= raw_nxt[`RCIMS_SRC_DONE];
      end
   end

   // End of sleep flag
   // Level until acknowledged, matching the level interrupt style
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wake_raw_r <= 1'b0;
      end else begin
         wake_raw_r <= raw_nxt[`RCIMS_SRC_WAKE];
      end
   end

   // Packet reception flag
   // A second reception before acknowledge merges into one
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         receive_raw_r <= 1'b0;
      end else begin
         receive_raw_r <= raw_nxt[`RCIMS_SRC_RX];
      end
   end

   // Base tick flag
   // Recorded during events too; the live gate hides it in status
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         tick_raw_r <= 1'b0;
      end else begin
         tick_raw_r <= raw_nxt[`RCIMS_SRC_TICK];
      end
   end

   // Raw word in the common bit order, for read-back and next state
   assign raw_word = {soft_irq_raw_r, event_prefetch_abort_raw_r, fine_target_raw_r,
      coarse_target_raw_r, fault_raw_r, cipher_raw_r, event_done_raw_r, wake_raw_r,
      receive_raw_r, tick_raw_r};

   // Per-source enables; reserved bits 14..10 are not stored
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         mask_r <= `RCIMS_MSK_RST;
      end else if (wr_fire && sel == rcims_pkg::RCIMS_SEL_MASK) begin
         mask_r <= PWDATA[`RCIMS_SRC_N-1:0];
      end
   end

   // Tick-during-event permission, written with the same word
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         tick_dev_r <= `RCIMS_TICKDEV_RST;
      end else if (wr_fire && sel == rcims_pkg::RCIMS_SEL_MASK) begin
         tick_dev_r <= PWDATA[`RCIMS_MSK_TICKDEV];
      end
   end

   // Masked view from the next raw state, so status and IRQ
   // follow the flags with no extra cycle of lag
   assign masked = apply_mask(raw_nxt, mask_r, tick_dev_r, EVENT_ACTIVE);

   // Registered masked status, also brought out for observation
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         status_r <= 10'h000;
      end else begin
         status_r <= masked;
      end
   end

   // Level interrupt: stays up until every masked bit is cleared
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |masked;
      end
   end

   // Read data mux for the selected register
   always_comb begin
      rd_word = 32'h0000_0000;
      case (sel)
         rcims_pkg::RCIMS_SEL_CTRL: rd_word = 32'h0000_0000;
         rcims_pkg::RCIMS_SEL_VERSION: rd_word = version_word;
         rcims_pkg::RCIMS_SEL_CONFIG: rd_word = config_word;
         rcims_pkg::RCIMS_SEL_MASK: begin
            rd_word[`RCIMS_SRC_N-1:0] = mask_r;
            rd_word[`RCIMS_MSK_TICKDEV] = tick_dev_r;
         end
         rcims_pkg::RCIMS_SEL_STAT: rd_word[`RCIMS_SRC_N-1:0] = status_r;
         rcims_pkg::RCIMS_SEL_RAW: rd_word[`RCIMS_SRC_N-1:0] = raw_word;
         rcims_pkg::RCIMS_SEL_ACK: rd_word = 32'h0000_0000;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // One wait state: PREADY rises in the second access cycle,
   // which keeps PREADY and PRDATA straight from flip-flops
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= rd_start;
      end
   end

   // Error answer for addresses outside the map
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pslverr_r <= 1'b0;
      end else begin
         pslverr_r <= rd_start && (sel == rcims_pkg::RCIMS_SEL_NONE);
      end
   end

   // Read data captured with PREADY; zero outside reads
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         prdata_r <= 32'h0000_0000;
      end else if (rd_start && !PWRITE) begin
         prdata_r <= rd_word;
      end else begin
         prdata_r <= 32'h0000_0000;
      end
   end

   // Outputs straight from flip-flops
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;
   assign PRDATA = prdata_r;
   assign IRQ_STATUS = status_r;
   assign IRQ = irq_r;

endmodule : rcims_top

// ---- bench/rcims_chk.sv ----
// Port assertions for the radio core interrupt mask/status front end.
// Assumes the top keeps its default identity parameters.
`timescale 1ns/1ps
`include "rcims_defines.svh"
module rcims_chk (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic EVENT_ACTIVE,
   input wire logic [8:0] SRC_EVENT,
   input wire logic [9:0] IRQ_STATUS,
   input wire logic IRQ
);
   default clocking dc @(posedge CLK); endclocking
   default disable iff (RST);
   // Read answer and completed write, held address
   wire logic rd_ok = PREADY && !PWRITE;
   wire logic wr_ok = PSEL && PENABLE && PREADY && PWRITE;
   a_irq_level: assert property (IRQ == (|IRQ_STATUS))
      else $error("irq level differs from status");
   a_ver_fields: assert property (rd_ok && PADDR == `RCIMS_ADDR_VERSION |->
      PRDATA == 32'h5A030405) else $error("version word wrong");
   a_cfg_bits: assert property (
      rd_ok && PADDR == `RCIMS_ADDR_CONFIG |-> PRDATA[29:24] == 6'h0F && PRDATA[6:0] == 7'h1F)
      else $error("config bits wrong");
   a_cfg_freq: assert property (rd_ok && PADDR == `RCIMS_ADDR_CONFIG |->
      PRDATA[13:8] == 6'h00) else $error("frequency field wrong");
   a_mask_rsvd: assert property (rd_ok && PADDR == `RCIMS_ADDR_MASK |->
      PRDATA[31:16] == 16'h0 && PRDATA[14:10] == 5'h0) else $error("mask reserved set");
   a_stat_rsvd: assert property (rd_ok && PADDR == `RCIMS_ADDR_STAT |->
      PRDATA[31:10] == 22'h0) else $error("status reserved set");
   a_ack_clear: assert property (wr_ok && PADDR == `RCIMS_ADDR_ACK &&
      (SRC_EVENT & PWDATA[8:0]) == 9'h0 |=> (IRQ_STATUS & $past(PWDATA[9:0])) == 10'h0)
      else $error("ack left status set");
   // Two quiet bus cycles: a mask write reaches status a cycle late; tick has a live gate
   a_stat_hold: assert property (!PSEL && !$past(PSEL) |=>
      (IRQ_STATUS[9:1] & $past(IRQ_STATUS[9:1])) == $past(IRQ_STATUS[9:1]))
      else $error("pending flag dropped");
   c_ack: cover property (wr_ok && PADDR == `RCIMS_ADDR_ACK && IRQ);
   c_irq: cover property ($rose(IRQ));
   c_err: cover property (PREADY && PSLVERR);
endmodule : rcims_chk

bind rcims_top rcims_chk rcims_chk_i (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .EVENT_ACTIVE(EVENT_ACTIVE), .SRC_EVENT(SRC_EVENT),
   .IRQ_STATUS(IRQ_STATUS), .IRQ(IRQ));

// ---- bench/tb_radio_core_irq_mask_status.sv ----
// Self-checking bench for the interrupt mask/status front end over APB.
// Assumes default parameters of rcims_top and the one-wait-state slave.
`timescale 1ns/1ps
`include "rcims_defines.svh"
module tb_radio_core_irq_mask_status;
   logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic EVENT_ACTIVE = 1'b0, IRQ, PREADY, PSLVERR;
   logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA;
   logic [8:0] SRC_EVENT = 9'h000;
   logic [9:0] IRQ_STATUS, m;
   logic [8:0] s, sm;
   logic [32:0] exp_q[$];
   integer n_fail = 0, n_checks = 0, cyc = 0, seed = 32'hf686;
   rcims_top rcims_top_i (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .EVENT_ACTIVE(EVENT_ACTIVE), .SRC_EVENT(SRC_EVENT),
      .IRQ_STATUS(IRQ_STATUS), .IRQ(IRQ));
   initial begin
      forever #12.5 CLK = ~CLK;
   end
   task automatic chk(input logic [32:0] seen, input logic [32:0] want);
      n_checks = n_checks + 1;
      if (seen !== want) begin
         n_fail = n_fail + 1;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : chk
   task print_verdict;
      $display("checks=%0d mismatches=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   // Hold the request until PREADY is sampled high, then release
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      // Ends once PREADY is sampled high; the hang guard stops a stuck wait
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task rd(input logic [31:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task pulse(input logic [8:0] v);
      @(posedge CLK);
      SRC_EVENT <= v;
      @(posedge CLK);
      SRC_EVENT <= 9'h0;
   endtask : pulse
   // Read answers matched against the oldest note
   always @(posedge CLK) begin
      if (PREADY === 1'b1 && PWRITE === 1'b0) begin
         if (exp_q.size() == 0) chk({PSLVERR, PRDATA}, 33'h1FFFFFFFF);
         else chk({PSLVERR, PRDATA}, exp_q.pop_front());
      end
   end
   // Hang guard, well above the run length
   always @(posedge CLK) begin
      cyc = cyc + 1;
      if (cyc > 5000) begin
         n_fail = n_fail + 1;
         print_verdict;
      end
   end
   initial begin
      repeat (6) @(posedge CLK);
      RST <= 1'b0;
      rd(`RCIMS_ADDR_VERSION, 33'h05A030405);
      rd(`RCIMS_ADDR_CONFIG, 33'h00F11001F);
      rd(`RCIMS_ADDR_MASK, 33'h00000811F);
      apb(1'b1, `RCIMS_ADDR_VERSION, 32'h0);
      rd(`RCIMS_ADDR_VERSION, 33'h05A030405);
      rd(32'h4000001C, 33'h100000000);
      $display("identity and reset test done");
      // Random masks and sources, reserved mask bits written as ones
      repeat (6) begin
         m = 10'($random(seed));
         s = 9'($random(seed));
         sm = s & m[8:0];
         apb(1'b1, `RCIMS_ADDR_MASK, 32'hFFFF_FC00 | m);
         pulse(s);
         rd(`RCIMS_ADDR_RAW, {24'h0, s});
         rd(`RCIMS_ADDR_STAT, {24'h0, sm});
         rd(`RCIMS_ADDR_MASK, {17'h0, 1'b1, 5'h0, m});
         chk({32'h0, IRQ}, {32'h0, |sm});
         apb(1'b1, `RCIMS_ADDR_ACK, 32'h3FF);
         rd(`RCIMS_ADDR_STAT, 33'h0);
         rd(`RCIMS_ADDR_RAW, 33'h0);
         chk({32'h0, IRQ}, 33'h0);
      end
      $display("mask and status test done");
      apb(1'b1, `RCIMS_ADDR_MASK, 32'h200);
      apb(1'b1, `RCIMS_ADDR_CTRL, 32'h1000_0000);
      rd(`RCIMS_ADDR_STAT, 33'h200);
      rd(`RCIMS_ADDR_CTRL, 33'h0);
      apb(1'b1, `RCIMS_ADDR_ACK, 32'h200);
      $display("soft request test done");
      // Tick during an event, permission off then on
      apb(1'b1, `RCIMS_ADDR_MASK, 32'h1);
      EVENT_ACTIVE <= 1'b1;
      pulse(9'h1);
      rd(`RCIMS_ADDR_RAW, 33'h1);
      rd(`RCIMS_ADDR_STAT, 33'h0);
      apb(1'b1, `RCIMS_ADDR_MASK, 32'h8001);
      rd(`RCIMS_ADDR_STAT, 33'h1);
      EVENT_ACTIVE <= 1'b0;
      $display("tick gate test done");
      repeat (4) @(posedge CLK);
      print_verdict;
   end
endmodule : tb_radio_core_irq_mask_status
